/* File: include/charger_ctrl_pkg.sv */
// Package: register map, reset values, field layout and timing of the charger control block
package charger_ctrl_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CHARGER_CONTROL_FIVE = 8'h14;
  localparam logic [7:0] OFS_POWER_POINT_CONTROL  = 8'h15;
  localparam logic [7:0] RST_CHARGER_CONTROL_FIVE = 8'h16;
  localparam logic [7:0] RST_POWER_POINT_CONTROL  = 8'haa;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_SHIP_FITTED    = 7;
  localparam int BIT_RESERVED       = 6;
  localparam int BIT_DISCHARGE_SNS  = 5;
  localparam int POS_DISCHARGE_LIM  = 3;
  localparam int BIT_INT_ILIM       = 2;
  localparam int BIT_EXT_ILIM       = 1;
  localparam int BIT_BATT_OCP       = 0;
  localparam int POS_FRACTION       = 5;
  localparam int POS_DELAY          = 3;
  localparam int POS_INTERVAL       = 1;
  localparam int BIT_TRACK_EN       = 0;

  // Fraction is (9 + code) / 16, so 0.5625 .. 1 in steps of 0.0625
  localparam logic [4:0] FRACTION_BASE = 5'h09;
  localparam int         FRACTION_SHIFT = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_NS       = 40;
  localparam int MS_NS          = 1000000;
  localparam int TICK_CYCLES    = MS_NS / CLOCK_NS;
  localparam int DELAY_MS_0     = 50;
  localparam int DELAY_MS_1     = 300;
  localparam int DELAY_MS_2     = 2000;
  localparam int INTERVAL_MS_0  = 30000;
  localparam int INTERVAL_MS_1  = 120000;
  localparam int INTERVAL_MS_2  = 600000;
  localparam int INTERVAL_MS_3  = 1800000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       discharge_sense_en;
    logic [1:0] discharge_current_limit_sel;
    logic       internal_input_current_limit_en;
    logic       external_input_limit_en;
    logic       batt_overcurrent_protect_en;
    logic [1:0] ship_drive_ctrl;
  } charger_ctrl_s;

  typedef struct packed {
    logic [2:0] open_voltage_fraction;
    logic [1:0] open_voltage_delay_sel;
    logic [1:0] interval_sel;
    logic       power_point_track_en;
  } track_ctrl_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SETTLE, ST_SAMPLE} track_state_e;

endpackage : charger_ctrl_pkg

/* File: rtl/charger_ctrl5_mppt_regs.sv */
// Charger control registers and open-circuit power-point tracking sequencer
//
// Functional notes
// R01 - Software sets ship-switch-fitted bit to match whether a ship switch is fitted.
// R02 - Ship switch not fitted: over-current enable and ship drive forced zero, writes ignored.
// R03 - Ship switch fitted: over-current enable and ship drive become writable and usable.
// R04 - Discharge sense enable bit 5, cleared by watchdog or register reset, gates sensing.
// R05 - Discharge limit bits 4-3: 3 A, 4 A, 5 A, off; reset code 10b.
// R06 - Internal input current limit enable bit 2, default 1, watchdog and register reset.
// R07 - External input limit enable bit 1, default 1, restored by register reset only.
// R08 - Over-current protection enable bit 0, default 0, cleared by watchdog or register reset.
// R09 - After measurement, voltage limit equals open voltage times (9+code)/16; default 101b.
// R10 - Measurement delay codes 0,1,2 give 50 ms, 300 ms, 2 s; default 01b.
// R11 - Measurement interval 30 s, 2, 10, 30 min; default 01b; register reset restores.
// R12 - Tracking enable bit 0, default 0, register reset; periodically measures open voltage.
// R13 - First register at 0x14 resets to 0x16; bit 6 reads zero.
// R14 - Tracking register at 0x15 resets to 0xaa.
// R15 - Discharge limit loads code 2 at reset despite table naming code 3.
// R16 - Reserved bit writes ignored; locked fields read their forced value.
`timescale 1ns/1ps

module charger_ctrl5_mppt_regs #(
  parameter int TICK_CYCLES = charger_ctrl_pkg::TICK_CYCLES,  // Clock cycles per millisecond
  parameter int VW          = 16                              // Voltage word width
) (
  input  wire logic                            clock,          // 25 MHz clock
  input  wire logic                            nrst,           // Async reset, active low
  input  wire logic [7:0]                      reg_addr,       // Register offset from host port
  input  wire logic [7:0]                      reg_wdata,      // Write data
  input  wire logic                            reg_wr,         // Write strobe, one cycle
  output logic      [7:0]                      reg_rdata,      // Read data, combinational
  input  wire logic                            watchdog_expire,// Watchdog expiry pulse
  input  wire logic                            reg_reset,      // Register reset command pulse
  input  wire logic [1:0]                      ship_drive_req, // Requested ship drive code
  input  wire logic [VW-1:0]                   open_voltage,   // Measured open bus voltage
  input  wire logic                            open_voltage_valid, // Measurement done pulse
  output charger_ctrl_pkg::charger_ctrl_s      charger_ctrl,   // Effective control fields
  output charger_ctrl_pkg::track_ctrl_s        track_ctrl,     // Tracking control fields
  output logic                                 measure_stop,   // Converter halted for sampling
  output logic      [VW-1:0]                   input_voltage_limit, // Tracked voltage limit
  output logic                                 limit_update    // Limit updated pulse
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] ctrl5_q;
  logic [7:0] track_q;
  logic [7:0] ctrl5_d;
  logic [7:0] track_d;

  // Address decode shared by the write strobes and the read mux
  wire sel_ctrl5 = (reg_addr == charger_ctrl_pkg::OFS_CHARGER_CONTROL_FIVE);
  wire sel_track = (reg_addr == charger_ctrl_pkg::OFS_POWER_POINT_CONTROL);
  wire wr_ctrl5  = reg_wr && sel_ctrl5;
  wire wr_track  = reg_wr && sel_track;
  wire fitted   = ctrl5_q[charger_ctrl_pkg::BIT_SHIP_FITTED];

  // Bits returned to their reset value by watchdog expiry; ship fitted and external limit survive it
  localparam logic [7:0] WDOG_MASK = 8'h3d;
  localparam logic [7:0] RSV_MASK  = 8'h40;

  wire [7:0] ctrl5_wdog = (ctrl5_q & ~WDOG_MASK)
                        | (charger_ctrl_pkg::RST_CHARGER_CONTROL_FIVE & WDOG_MASK); // R04 R06 R08
  // Register reset keeps ship fitted, which only a power-on or a host write clears
  wire [7:0] ctrl5_rst  = {ctrl5_q[charger_ctrl_pkg::BIT_SHIP_FITTED],
                           charger_ctrl_pkg::RST_CHARGER_CONTROL_FIVE[6:0]}; // R07
  wire [7:0] ctrl5_wr   = reg_wdata & ~RSV_MASK; // R16
  // Register reset beats watchdog beats host write; a write that meets
  // either reset event in the same cycle is lost
  wire [7:0] ctrl5_pre  = reg_reset       ? ctrl5_rst  :
                          watchdog_expire ? ctrl5_wdog :
                          wr_ctrl5        ? ctrl5_wr   : ctrl5_q;
  // Lock follows the new fitted value so a write setting both takes effect at once
  wire       fit_next   = ctrl5_pre[charger_ctrl_pkg::BIT_SHIP_FITTED]; // R01
  assign ctrl5_d = {ctrl5_pre[7:1],
                    ctrl5_pre[charger_ctrl_pkg::BIT_BATT_OCP] & fit_next}; // R02 R03

  // Watchdog leaves the tracking settings alone
  assign track_d = reg_reset ? charger_ctrl_pkg::RST_POWER_POINT_CONTROL :
                   wr_track  ? reg_wdata : track_q; // R11 R12

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl5_q <= charger_ctrl_pkg::RST_CHARGER_CONTROL_FIVE; // R13 R15
    end else begin
      ctrl5_q <= ctrl5_d;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      track_q <= charger_ctrl_pkg::RST_POWER_POINT_CONTROL;  // R14
    end else begin
      track_q <= track_d;
    end
  end

  // ****************************************
  // Read path and field outputs
  // ****************************************
  // Reserved bit is never stored, masked again so a read can never show it
  wire [7:0] ctrl5_view = ctrl5_q & ~RSV_MASK; // R13 R16
  assign reg_rdata = sel_ctrl5 ? ctrl5_view :
                     sel_track ? track_q    : 8'h00;

  assign charger_ctrl.discharge_sense_en =
    ctrl5_q[charger_ctrl_pkg::BIT_DISCHARGE_SNS]; // R04
  assign charger_ctrl.discharge_current_limit_sel =
    ctrl5_q[charger_ctrl_pkg::POS_DISCHARGE_LIM +: 2]; // R05
  assign charger_ctrl.internal_input_current_limit_en =
    ctrl5_q[charger_ctrl_pkg::BIT_INT_ILIM]; // R06
  assign charger_ctrl.external_input_limit_en =
    ctrl5_q[charger_ctrl_pkg::BIT_EXT_ILIM]; // R07
  assign charger_ctrl.batt_overcurrent_protect_en =
    ctrl5_q[charger_ctrl_pkg::BIT_BATT_OCP] & fitted; // R08 R02
  assign charger_ctrl.ship_drive_ctrl = fitted ? ship_drive_req : 2'h0; // R02 R03

  assign track_ctrl.open_voltage_fraction  = track_q[charger_ctrl_pkg::POS_FRACTION +: 3];
  assign track_ctrl.open_voltage_delay_sel = track_q[charger_ctrl_pkg::POS_DELAY +: 2];
  assign track_ctrl.interval_sel           = track_q[charger_ctrl_pkg::POS_INTERVAL +: 2];
  assign track_ctrl.power_point_track_en   = track_q[charger_ctrl_pkg::BIT_TRACK_EN];

  // ****************************************
  // Millisecond tick
  // ****************************************
  // Free running, so the first millisecond of a settle may be up to one tick short
  logic [15:0] tick_q;
  wire         tick = (tick_q == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) tick_q <= 16'h0000;
    else       tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
  end

  // ****************************************
  // Open-circuit sampling sequencer
  // ****************************************
  // Delay and interval tables in milliseconds
  function automatic logic [20:0] delay_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0:    delay_ms = 21'(charger_ctrl_pkg::DELAY_MS_0);
      2'h1:    delay_ms = 21'(charger_ctrl_pkg::DELAY_MS_1);
      default: delay_ms = 21'(charger_ctrl_pkg::DELAY_MS_2); // Code 3 undefined, held at 2 s
    endcase
  endfunction : delay_ms

  function automatic logic [20:0] interval_ms(input logic [1:0] sel);
    unique case (sel)
      2'h0: interval_ms = 21'(charger_ctrl_pkg::INTERVAL_MS_0);
      2'h1: interval_ms = 21'(charger_ctrl_pkg::INTERVAL_MS_1);
      2'h2: interval_ms = 21'(charger_ctrl_pkg::INTERVAL_MS_2);
      2'h3: interval_ms = 21'(charger_ctrl_pkg::INTERVAL_MS_3);
    endcase
  endfunction : interval_ms

  charger_ctrl_pkg::track_state_e state_q;
  charger_ctrl_pkg::track_state_e state_d;
  logic [20:0]                    ms_q;
  logic [20:0]                    ms_d;
  logic [VW-1:0]                  limit_q;
  logic [VW-1:0]                  limit_d;
  logic                           update_q;

  wire        track_en  = track_ctrl.power_point_track_en;
  wire [20:0] dly_tgt   = delay_ms(track_ctrl.open_voltage_delay_sel);   // R10
  wire [20:0] int_tgt   = interval_ms(track_ctrl.interval_sel);          // R11
  wire [4:0]  frac_mul  = charger_ctrl_pkg::FRACTION_BASE
                        + {2'h0, track_ctrl.open_voltage_fraction};
  wire [VW+4:0] product = open_voltage * frac_mul;                      // R09
  wire [VW-1:0] scaled  = product[charger_ctrl_pkg::FRACTION_SHIFT +: VW];
  wire          sampled = (state_q == charger_ctrl_pkg::ST_SAMPLE) && open_voltage_valid;

  always_comb begin
    state_d = state_q;
    ms_d    = tick ? ms_q + 21'h000001 : ms_q;
    limit_d = sampled ? scaled : limit_q; // R09
    unique case (state_q)
      charger_ctrl_pkg::ST_IDLE: begin
        ms_d = 21'h000000;
        // First measurement follows enabling without waiting an interval
        if (track_en) state_d = charger_ctrl_pkg::ST_SETTLE; // R12
      end
      charger_ctrl_pkg::ST_WAIT: begin
        if (ms_q >= int_tgt) begin // R11
          state_d = charger_ctrl_pkg::ST_SETTLE;
          ms_d    = 21'h000000;
        end
      end
      charger_ctrl_pkg::ST_SETTLE: begin
        if (ms_q >= dly_tgt) state_d = charger_ctrl_pkg::ST_SAMPLE; // R10
      end
      charger_ctrl_pkg::ST_SAMPLE: begin
        if (open_voltage_valid) begin
          state_d = charger_ctrl_pkg::ST_WAIT;
          ms_d    = 21'h000000;
        end
      end
    endcase
    if (!track_en) state_d = charger_ctrl_pkg::ST_IDLE; // R12
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q  <= charger_ctrl_pkg::ST_IDLE;
      ms_q     <= 21'h000000;
      limit_q  <= '0;
      update_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      ms_q     <= ms_d;
      limit_q  <= limit_d;
      update_q <= sampled;
    end
  end

  // Converter held off through settle and sample so the bus is unloaded
  assign measure_stop        = (state_q == charger_ctrl_pkg::ST_SETTLE)
                             || (state_q == charger_ctrl_pkg::ST_SAMPLE);
  assign input_voltage_limit = limit_q;
  assign limit_update        = update_q;

endmodule : charger_ctrl5_mppt_regs

/* File: test/charger_ctrl_properties.sv */
// Checker: concurrent properties on the charger control register block ports
`timescale 1ns/1ps
module charger_ctrl_checker #(
  parameter int TICK_CYCLES = 4,  // Clock cycles per ms
  parameter int VW          = 16  // Voltage word width
) (
  input wire logic                           clock,               // Clock
  input wire logic                           nrst,                // Async reset, active low
  input wire logic [7:0]                     reg_addr,            // Register offset
  input wire logic [7:0]                     reg_wdata,           // Write data
  input wire logic                           reg_wr,              // Write strobe
  input wire logic [7:0]                     reg_rdata,           // Read data
  input wire logic                           watchdog_expire,     // Watchdog pulse
  input wire logic                           reg_reset,           // Register reset pulse
  input wire logic [1:0]                     ship_drive_req,      // Requested ship drive
  input wire logic [VW-1:0]                  open_voltage,        // Open bus voltage
  input wire logic                           open_voltage_valid,  // Measurement done
  input wire charger_ctrl_pkg::charger_ctrl_s charger_ctrl,       // Control fields
  input wire charger_ctrl_pkg::track_ctrl_s  track_ctrl,          // Tracking fields
  input wire logic                           measure_stop,        // Converter halted
  input wire logic [VW-1:0]                  input_voltage_limit, // Tracked limit
  input wire logic                           limit_update         // Limit updated pulse
);
  // ****************************************
  // Properties
  // ****************************************
  // Product kept one cycle, since the limit lags the measurement by a cycle
  logic [VW+4:0] prod_q;
  always_ff @(posedge clock) begin
    prod_q <= open_voltage * (5'h09 + track_ctrl.open_voltage_fraction);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_reserved_reads_zero: assert property ((reg_addr == 8'h14) |-> !reg_rdata[6])
    else $error("reserved bit reads one");
  a_ship_drive_gate: assert property (
    (reg_addr == 8'h14) |-> charger_ctrl.ship_drive_ctrl ==
    (reg_rdata[7] ? ship_drive_req : 2'h0)) else $error("ship drive not gated");
  a_regreset_defaults: assert property (reg_reset |=> charger_ctrl[7:2] == 6'h16 &&
    track_ctrl == 8'haa) else $error("register reset values wrong");
  a_watchdog_defaults: assert property (
    watchdog_expire && !reg_reset && !(reg_wr && reg_addr == 8'h15) |=>
    {charger_ctrl[7:4], charger_ctrl[2]} == 5'h0a && track_ctrl == $past(track_ctrl) &&
    charger_ctrl.external_input_limit_en == $past(charger_ctrl.external_input_limit_en))
    else $error("watchdog values wrong");
  a_write_track_reg: assert property (
    reg_wr && reg_addr == 8'h15 && !reg_reset |=>
    track_ctrl == $past(reg_wdata)) else $error("tracking write lost");
  a_limit_value: assert property (
    limit_update |-> input_voltage_limit == prod_q[VW+3:4] && !measure_stop)
    else $error("tracked limit wrong");
  a_track_start: assert property ($rose(track_ctrl.power_point_track_en) |=> measure_stop)
    else $error("tracking did not start");
  a_track_off: assert property (!track_ctrl.power_point_track_en [*2] |-> !measure_stop)
    else $error("sampling while disabled");
  c_watchdog: cover property (watchdog_expire);
  c_reg_reset: cover property (reg_reset);
  c_limit: cover property (limit_update);
endmodule : charger_ctrl_checker

bind charger_ctrl5_mppt_regs charger_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES), .VW(VW)) u_chk (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .watchdog_expire(watchdog_expire), .reg_reset(reg_reset),
  .ship_drive_req(ship_drive_req), .open_voltage(open_voltage),
  .open_voltage_valid(open_voltage_valid), .charger_ctrl(charger_ctrl),
  .track_ctrl(track_ctrl), .measure_stop(measure_stop),
  .input_voltage_limit(input_voltage_limit), .limit_update(limit_update));

/* File: test/test_charger_ctrl5_mppt_regs.sv */
// Testbench: register access and tracking sequence of the charger control block
`timescale 1ns/1ps
module test_charger_ctrl5_mppt_regs;
  // ****************************************
  // Signals, tasks and sequence
  // ****************************************
  logic clock, nrst, reg_wr, watchdog_expire, reg_reset, open_voltage_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] ship_drive_req;
  logic [15:0] open_voltage, input_voltage_limit;
  logic measure_stop, limit_update;
  charger_ctrl_pkg::charger_ctrl_s charger_ctrl;
  charger_ctrl_pkg::track_ctrl_s   track_ctrl;
  int n_errors = 0;
  int checked = 0;

  charger_ctrl5_mppt_regs #(.TICK_CYCLES(4), .VW(16)) uut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .watchdog_expire(watchdog_expire), .reg_reset(reg_reset),
    .ship_drive_req(ship_drive_req), .open_voltage(open_voltage),
    .open_voltage_valid(open_voltage_valid), .charger_ctrl(charger_ctrl),
    .track_ctrl(track_ctrl), .measure_stop(measure_stop),
    .input_voltage_limit(input_voltage_limit), .limit_update(limit_update));

  always #20 clock = ~clock;

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // All tasks enter and leave just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    #1;
    check(reg_rdata, exp);
  endtask : rd

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  task automatic wait_stop(input int lim);
    int i;
    i = 0;
    while (measure_stop !== 1'b1 && i < lim) begin
      tick(1);
      i++;
    end
    if (measure_stop !== 1'b1) begin
      check(measure_stop, 1'b1);
      end_sim();
    end
  endtask : wait_stop

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    reg_addr = 8'h14;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    watchdog_expire = 1'b0;
    reg_reset = 1'b0;
    ship_drive_req = 2'h3;
    open_voltage = 16'h1234;
    open_voltage_valid = 1'b0;
    tick(3);
    nrst = 1'b1;
    rd(8'h14, 8'h16);
    rd(8'h15, 8'haa);
    rd(8'h20, 8'h00);
    wr(8'h14, 8'h7f);
    rd(8'h14, 8'h3e);
    check(charger_ctrl, 8'hf8);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'hbf);
    check(charger_ctrl, 8'hff);
    wr(8'h14, 8'ha1);
    tick(1);
    wr(8'h15, 8'h54);
    pulse(watchdog_expire);
    rd(8'h14, 8'h94);
    check(charger_ctrl, 8'h53);
    rd(8'h15, 8'h54);
    pulse(reg_reset);
    rd(8'h14, 8'h96);
    rd(8'h15, 8'haa);
    for (int i = 0; i < 8; i++) begin
      logic [7:0] v;
      v = {i[2:0], i[1:0], ~i[1:0], 1'b0};
      wr(8'h15, v);
      rd(8'h15, v);
      check(track_ctrl, v);
    end
    // Fraction 0.75, delay 50 ms is 200 cycles at the reduced tick
    wr(8'h15, 8'h61);
    wait_stop(4);
    tick(150);
    pulse(open_voltage_valid);
    check(limit_update, 1'b0);
    check(input_voltage_limit, 16'h0000);
    tick(61);
    pulse(open_voltage_valid);
    check(limit_update, 1'b1);
    check(input_voltage_limit, 16'h0da7);
    check(measure_stop, 1'b0);
    wr(8'h15, 8'h60);
    tick(1);
    check(measure_stop, 1'b0);
    end_sim();
  end
endmodule : test_charger_ctrl5_mppt_regs
